// ==== hw/cruise_msg_consts.vh ====
// constants for the cruise set-speed and cancel message handler
// Functional notes
// - send speed report on qualifier toggle or speed change, at most once per 300 ms
// - receiver discards any header whose upper nibble is odd
// - speed report carries qualifier plus unsigned 8-bit kph set speed
// - source qualifier and set speed are refreshed every 25 ms
// - answer each cancel load with a report of the latest received qualifier
// - drop cruise on cancel load with qualifier 0; resume only on resume switch
`ifndef CRUISE_MSG_CONSTS_VH
`define CRUISE_MSG_CONSTS_VH
`define CLK_KHZ 50000
`define MIN_GAP_MS 300
// cycle counts are the ms figure times the clock in kHz, sized to the 24-bit timers
`define MIN_GAP_CYC 24'hE4E1C0
`define LOOP_MS 25
`define LOOP_CYC 24'h1312D0
`define RETRY_MS 300
`define RETRY_CYC 24'hE4E1C0
`define PRI_RPT 8'h88
`define PRI_RPT_MASK 8'hF0
`define PRI_ODD_BIT 4
`define ID_FROM_PT 8'h63
`define ID_TO_PT 8'h62
`define SRC_PT 8'h10
`define FN_SPEED 7'h02
`define FN_ACK 7'h42
`define FN_CANCEL 7'h07
`define Q_BIT 7
`define HDR_B1_LSB 24
`define HDR_ID_MSB 23
`define HDR_ID_LSB 16
`define HDR_FN_MSB 6
`define HDR_FN_LSB 0
`define CANCEL_VALUE 1'b0
`define CNT_W 24
`endif

// ==== hw/frame_gap_timer.v ====
// down-counting interval timer with a one-cycle expiry pulse
`timescale 1ns/1ns
module frame_gap_timer #(
  parameter [23:0] LOAD_CYC = 24'h000001
) (
  input wire clk_i, // clock
  input wire rst_n_i, // synchronised reset, active low
  input wire start_i, // reload the count
  output reg done_o, // one-cycle pulse at expiry
  output wire busy_o // count still running
);
  reg [23:0] cnt_q;
  assign busy_o = (cnt_q != 24'h000000);
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= 24'h000000;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= (cnt_q == 24'h000001) && !start_i;
      if (start_i)
        cnt_q <= LOAD_CYC;
      else if (busy_o)
        cnt_q <= cnt_q - 24'h000001;
    end
  end
endmodule

// ==== hw/cruise_speed_msg_handler.v ====
// cruise set-speed report and cruise-cancel message handler, powertrain side
`timescale 1ns/1ns
`include "cruise_msg_consts.vh"
module cruise_speed_msg_handler #(
  parameter [23:0] GAP_CYC = `MIN_GAP_CYC,
  parameter [23:0] LOOP_CYC = `LOOP_CYC,
  parameter [23:0] RETRY_CYC = `RETRY_CYC
) (
  input wire clk_i, // 50 MHz clock
  input wire resetn_i, // async reset, active low
  input wire cruise_active_i, // live cruise-active qualifier
  input wire [7:0] set_speed_i, // live set speed, kph
  input wire resume_i, // resume switch press, pulse
  input wire rx_valid_i, // received header strobe
  input wire [31:0] rx_header_i, // received header, first byte in [31:24]
  input wire tx_ready_i, // transmitter takes tx_header_o
  output reg tx_valid_o, // header waiting to go out
  output reg [31:0] tx_header_o, // header to transmit
  output reg cruise_drop_o, // cruise dropped by cancel, held
  output reg cancel_q_o // latest received cancel qualifier
);
  reg rst_s1_q;
  reg rst_n_q;
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  wire loop_tick;
  wire gap_busy;
  wire retry_tick;
  reg loop_start_q;
  reg gap_start_q;
  reg retry_start_q;
  frame_gap_timer #(.LOAD_CYC(LOOP_CYC)) u_loop (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .start_i(loop_start_q),
    .done_o(loop_tick),
    .busy_o()
  );
  frame_gap_timer #(.LOAD_CYC(GAP_CYC)) u_gap (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .start_i(gap_start_q),
    .done_o(),
    .busy_o(gap_busy)
  );
  frame_gap_timer #(.LOAD_CYC(RETRY_CYC)) u_retry (
    .clk_i(clk_i),
    .rst_n_i(rst_n_q),
    .start_i(retry_start_q),
    .done_o(retry_tick),
    .busy_o()
  );

  // header decode; a valid header is dropped outright when its top nibble is odd
  wire rx_ok = rx_valid_i && !rx_header_i[`HDR_B1_LSB + `PRI_ODD_BIT];
  // low bit of the first byte marks a request or acknowledge, clear for a load
  wire rx_b1_odd = rx_header_i[`HDR_B1_LSB];
  wire [7:0] rx_id = rx_header_i[`HDR_ID_MSB:`HDR_ID_LSB];
  wire [6:0] rx_fn = rx_header_i[`HDR_FN_MSB:`HDR_FN_LSB];
  wire rx_q = rx_header_i[`Q_BIT];
  wire rx_to_pt = rx_ok && (rx_id == `ID_TO_PT);
  wire rx_ack = rx_to_pt && (rx_fn == `FN_ACK) && rx_b1_odd;
  wire rx_poll = rx_to_pt && (rx_fn == `FN_SPEED) && rx_b1_odd;
  wire rx_load = rx_to_pt && (rx_fn == `FN_CANCEL) && !rx_b1_odd;

  reg q_src_q;
  reg [7:0] speed_src_q;
  reg q_sent_q;
  reg [7:0] speed_sent_q;
  reg change_pend_q;
  reg poll_pend_q;
  reg retry_pend_q;
  reg await_ack_q;
  reg cancel_pend_q;
  reg primed_q;

  // sample the sources on the application loop only
  always @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      q_src_q <= 1'b0;
      speed_src_q <= 8'h00;
      loop_start_q <= 1'b1;
      primed_q <= 1'b0;
    end
    else
    begin
      loop_start_q <= loop_tick;
      if (loop_tick)
      begin
        q_src_q <= cruise_active_i;
        speed_src_q <= set_speed_i;
        primed_q <= 1'b1;
      end
    end
  end

  wire changed = primed_q && ((q_src_q != q_sent_q) || (speed_src_q != speed_sent_q));
  wire change_due = change_pend_q && !gap_busy;
  wire hold = tx_valid_o && !tx_ready_i;
  wire send_cancel = !hold && cancel_pend_q;
  wire send_speed = !hold && !cancel_pend_q
    && (poll_pend_q || retry_pend_q || change_due);

  // one transmit slot; a cancel report goes ahead of any speed report
  always @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      tx_valid_o <= 1'b0;
      tx_header_o <= 32'h00000000;
      q_sent_q <= 1'b0;
      speed_sent_q <= 8'h00;
      gap_start_q <= 1'b0;
      retry_start_q <= 1'b0;
    end
    else
    begin
      gap_start_q <= 1'b0;
      retry_start_q <= 1'b0;
      if (tx_valid_o && tx_ready_i)
        tx_valid_o <= 1'b0;
      if (send_speed)
      begin
        tx_valid_o <= 1'b1;
        tx_header_o <= {`PRI_RPT, `ID_FROM_PT, speed_src_q, q_src_q, `FN_SPEED};
        q_sent_q <= q_src_q;
        speed_sent_q <= speed_src_q;
        // polls and retries bypass the spacing, so only a change send restarts it
        if (change_due)
          gap_start_q <= 1'b1;
        retry_start_q <= 1'b1;
      end
      else if (send_cancel)
      begin
        tx_valid_o <= 1'b1;
        tx_header_o <= {`PRI_RPT, `ID_FROM_PT, `SRC_PT, cancel_q_o, `FN_CANCEL};
      end
    end
  end

  // a send carries the sampled values, so it also serves a change seen in its cycle
  always @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      change_pend_q <= 1'b0;
    else if (send_speed)
      change_pend_q <= 1'b0;
    else if (changed)
      change_pend_q <= 1'b1;
  end

  // a poll that lands while a report goes out still earns its own answer
  always @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      poll_pend_q <= 1'b0;
    else if (rx_poll)
      poll_pend_q <= 1'b1;
    else if (send_speed)
      poll_pend_q <= 1'b0;
  end

  always @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      retry_pend_q <= 1'b0;
    else if (retry_tick && await_ack_q && !rx_ack)
      retry_pend_q <= 1'b1;
    else if (send_speed || rx_ack)
      retry_pend_q <= 1'b0;
  end

  always @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      await_ack_q <= 1'b0;
    else if (send_speed)
      await_ack_q <= 1'b1;
    else if (rx_ack)
      await_ack_q <= 1'b0;
  end

  always @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      cancel_pend_q <= 1'b0;
    else if (rx_load)
      cancel_pend_q <= 1'b1;
    else if (send_cancel)
      cancel_pend_q <= 1'b0;
  end

  // the drop stays until the resume switch; a zero load in the same cycle wins
  always @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cancel_q_o <= 1'b0;
      cruise_drop_o <= 1'b0;
    end
    else
    begin
      if (rx_load)
        cancel_q_o <= rx_q;
      if (rx_load && (rx_q == `CANCEL_VALUE))
        cruise_drop_o <= 1'b1;
      else if (resume_i)
        cruise_drop_o <= 1'b0;
    end
  end
endmodule

// ==== tb/cruise_msg_checker.sv ====
// port assertions for the cruise message handler
`timescale 1ns/1ns
module cruise_msg_checker(
  input wire clk_i,
  input wire resetn_i,
  input wire resume_i,
  input wire rx_valid_i,
  input wire [31:0] rx_header_i,
  input wire tx_ready_i,
  input wire tx_valid_o,
  input wire [31:0] tx_header_o,
  input wire cruise_drop_o,
  input wire cancel_q_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence load_s;
    rx_valid_i && !rx_header_i[28] && !rx_header_i[24] && rx_header_i[23:16] == 8'h62
      && rx_header_i[6:0] == 7'h07;
  endsequence
  sequence cancel_rpt_s;
    ##[1:2] tx_valid_o && tx_header_o == {24'h886310, cancel_q_o, 7'h07};
  endsequence
  cancel_answer_a: assert property (load_s |-> cancel_rpt_s)
    else $error("cancel load not answered");
  latest_q_a: assert property (load_s |=> cancel_q_o == $past(rx_header_i[7]))
    else $error("cancel state not latched");
  drop_zero_a: assert property (load_s ##0 !rx_header_i[7] |=> cruise_drop_o)
    else $error("cruise not dropped");
  drop_hold_a: assert property (cruise_drop_o && !resume_i |=> cruise_drop_o)
    else $error("drop released early");
  resume_clr_a: assert property (resume_i && !rx_valid_i |=> !cruise_drop_o)
    else $error("resume ignored");
  odd_refuse_a: assert property (rx_valid_i && rx_header_i[28] |=> $stable(cancel_q_o))
    else $error("odd header taken");
  tx_stand_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_header_o))
    else $error("header dropped");
  frame_form_a: assert property (tx_valid_o |-> tx_header_o[31:16] == 16'h8863
    && (tx_header_o[6:0] == 7'h02 || tx_header_o[15:8] == 8'h10 && tx_header_o[6:0] == 7'h07))
    else $error("bad report header");
endmodule
bind cruise_speed_msg_handler cruise_msg_checker chk(.clk_i, .resetn_i, .resume_i,
  .rx_valid_i, .rx_header_i, .tx_ready_i, .tx_valid_o, .tx_header_o, .cruise_drop_o, .cancel_q_o);

// ==== tb/platform_model.sv ====
// platform stand-in: takes reports, sends a cancel load when its cancel level moves
`timescale 1ns/1ns
module platform_model(
  input wire clk_i,
  input wire stall_i,
  input wire cancel_lvl_i,
  output reg ready_o = 1'b1,
  output reg ld_valid_o = 1'b0,
  output reg [31:0] ld_hdr_o = 32'h00000000
);
  reg last_q = 1'b0;
  always @(negedge clk_i)
  begin
    ready_o <= !stall_i;
    ld_valid_o <= cancel_lvl_i != last_q;
    // idle header toggles so a stale load never looks valid
    ld_hdr_o <= (cancel_lvl_i != last_q) ? {24'h886200, cancel_lvl_i, 7'h07} : ~ld_hdr_o;
    last_q <= cancel_lvl_i;
  end
endmodule

// ==== tb/cruise_speed_msg_handler_bench.sv ====
// bench for the cruise set-speed and cancel handler
`timescale 1ns/1ns
module cruise_speed_msg_handler_bench;
  reg clk = 1'b0, rstn = 1'b0, act = 1'b0, res = 1'b0, tv = 1'b0, stall = 1'b0, cl = 1'b0;
  reg [7:0] spd = 8'h00;
  reg [31:0] th = 32'h00000000;
  wire pv, rdy, txv, drop, cq;
  wire [31:0] ph, txh;
  integer bad_count = 0, tests_run = 0, n;
  always #10 clk = ~clk;
  cruise_speed_msg_handler #(.GAP_CYC(24'h000014), .LOOP_CYC(24'h00000A),
    .RETRY_CYC(24'h000028)) uut(.clk_i(clk), .resetn_i(rstn), .cruise_active_i(act),
    .set_speed_i(spd), .resume_i(res), .rx_valid_i(pv | tv), .rx_header_i(pv ? ph : th),
    .tx_ready_i(rdy), .tx_valid_o(txv), .tx_header_o(txh), .cruise_drop_o(drop),
    .cancel_q_o(cq));
  platform_model pm(.clk_i(clk), .stall_i(stall), .cancel_lvl_i(cl), .ready_o(rdy),
    .ld_valid_o(pv), .ld_hdr_o(ph));
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task chk(input [63:0] nm, input [31:0] e, input [31:0] s);
  begin
    tests_run = tests_run + 1;
    if (e !== s)
    begin
      bad_count = bad_count + 1;
      $display("MISMATCH %0s exp %h got %h", nm, e, s);
    end
  end
  endtask
  task rx(input [31:0] h);
  begin
    @(negedge clk);
    th = h;
    tv = 1'b1;
    @(negedge clk);
    tv = 1'b0;
  end
  endtask
  task want(input [31:0] e);
  begin
    n = 0;
    while (txv !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n = n + 1;
    end
    if (n >= 200)
    begin
      bad_count = bad_count + 1;
      report_and_stop;
    end
    chk("header", e, txh);
    @(negedge clk);
  end
  endtask
  task quiet(input integer k);
  begin
    repeat (k)
    begin
      @(negedge clk);
      chk("quiet", 32'h0, {31'h0, txv});
    end
  end
  endtask
  task t_speed;
  begin
    act = 1'b1;
    spd = 8'h64;
    want(32'h88636482);
    rx(32'h89620042);
    quiet(60);
    $display("speed test done");
  end
  endtask
  task t_retry;
  begin
    spd = 8'h65;
    want(32'h88636582);
    want(32'h88636582);
    rx(32'h89620042);
    quiet(50);
    $display("retry test done");
  end
  endtask
  task t_poll;
  begin
    @(posedge clk);
    stall = 1'b1;
    rx(32'h89620002);
    want(32'h88636582);
    repeat (8) @(negedge clk);
    @(posedge clk);
    stall = 1'b0;
    @(negedge clk);
    want(32'h88636582);
    rx(32'h89620042);
    rx(32'h99620002);
    quiet(30);
    $display("poll test done");
  end
  endtask
  task t_gap;
  begin
    spd = 8'h66;
    want(32'h88636682);
    rx(32'h89620042);
    spd = 8'h67;
    // the next change must wait out the 20-cycle spacing, about 3 cycles of it already spent
    want(32'h88636782);
    chk("gap", 32'h1, {31'h0, n >= 16});
    rx(32'h89620042);
    quiet(45);
    $display("gap test done");
  end
  endtask
  task t_cancel;
  begin
    @(posedge clk);
    cl = 1'b1;
    want(32'h88631087);
    chk("drop", 32'h0, {31'h0, drop});
    @(posedge clk);
    cl = 1'b0;
    want(32'h88631007);
    chk("drop", 32'h1, {31'h0, drop});
    rx(32'h98620087);
    quiet(20);
    chk("cancel", 32'h0, {31'h0, cq});
    res = 1'b1;
    @(negedge clk);
    res = 1'b0;
    @(negedge clk);
    chk("drop", 32'h0, {31'h0, drop});
    $display("cancel test done");
  end
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    t_speed;
    t_retry;
    t_poll;
    t_gap;
    t_cancel;
    report_and_stop;
  end
endmodule
